// [shared/asp_pkg.sv]
// Constants shared by the asynchronous serial port and its register map.
// Assumes a 32-bit APB host and a 50 MHz system clock.
// Summary of operation
// - Variable 8-bit mode frames: low start, eight data bits LSB first, high stop.
// - In that mode the received byte goes to the buffer, stop bit to rx_ninth_bit.
// - Variable modes run at baud generator overflow rate divided by sixteen.
// - Buffer write requests sending; start bit waits for the next bit counter rollover.
// - Transmitter sends start, data, stop; tx_done_flag rises as stop begins.
// - Receiver works only with rx_enable high, starting on a falling edge.
// - Input sampled at sixteen times bit rate; falling edge clears the bit counter.
// - Each bit is the majority of samples at counter states seven, eight, nine.
// - A start bit sampled high aborts reception and rearms edge detection.
// - 8-bit mode accepts a frame only if rx_done_flag clear and stop or filter off.
// - After each frame watch for an edge; software clears rx_done_flag first.
// - 9-bit modes frame: start, eight data LSB first, ninth bit, high stop.
// - Buffer write in 9-bit modes copies tx_ninth_bit into the ninth shift position.
// - Fixed 9-bit mode sets tx_done_flag at the eleventh rollover after the write.
// - Fixed 9-bit mode bit rate is clock/64, or clock/32 with baud_double_select.
// - 9-bit modes drop stop; accept if flag clear and filter off or addressed.
// - Variable 9-bit mode uses 9-bit framing with the dedicated baud generator.
// - Baud generator: 15-bit up counter reloaded, overflowing every 32768-reload clocks.
// - Variable bit period is 16*(32768-reload) plus baud_fine_adjust clocks.
// - Shift mode rate is clock/12, or clock/4 with multiproc_enable set.
// - With multiproc_enable in 9-bit modes only ninth-bit-one frames raise the flag.
// - Mode field 01 is 8-bit variable, 10 is 9-bit fixed, 11 is 9-bit variable.
// - Given address compares only masked bits; broadcast is OR of both, zeros ignored.
// - Address and mask reset to zero so every address matches.
package asp_pkg;
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_DATA  = 8'h04;
	localparam logic [7:0] OFS_BAUD  = 8'h08;
	localparam logic [7:0] OFS_FINE  = 8'h0c;
	localparam logic [7:0] OFS_PCTL  = 8'h10;
	localparam logic [7:0] OFS_SLAVE = 8'h14;
	localparam logic [7:0] OFS_MASK  = 8'h18;
	// Control register field positions
	localparam int B_MODE_HI = 7;
	localparam int B_MODE_LO = 6;
	localparam int B_MPE     = 5;
	localparam int B_RXEN    = 4;
	localparam int B_TX9     = 3;
	localparam int B_RX9     = 2;
	localparam int B_TXDONE  = 1;
	localparam int B_RXDONE  = 0;
	localparam logic [7:0]  CTRL_RST  = 8'h00;
	localparam logic [14:0] BAUD_RST  = 15'h0000;
	localparam logic [7:0]  ADDR_RST  = 8'h00;
	localparam logic [1:0]  MODE_SHIFT = 2'h0;
	localparam logic [1:0]  MODE_VAR8  = 2'h1;
	localparam logic [1:0]  MODE_FIX9  = 2'h2;
	localparam logic [1:0]  MODE_VAR9  = 2'h3;
	// Timing: oversampling and fixed dividers, in system clocks
	localparam int OVERSAMPLE = 16;
	localparam int FIX_SLOW   = 64;
	localparam int FIX_FAST   = 32;
	localparam logic [1:0] FIX_SLOW_TICK = 2'((FIX_SLOW / OVERSAMPLE) - 1);
	localparam logic [1:0] FIX_FAST_TICK = 2'((FIX_FAST / OVERSAMPLE) - 1);
	localparam logic [3:0] SHIFT_SLOW = 4'(12 - 1);
	localparam logic [3:0] SHIFT_FAST = 4'(4 - 1);
	localparam logic [3:0] CNT_LAST = 4'(OVERSAMPLE - 1);
	localparam logic [3:0] SMP_A = 4'h7;
	localparam logic [3:0] SMP_B = 4'h8;
	localparam logic [3:0] SMP_C = 4'h9;
	localparam logic [14:0] BAUD_MAX = 15'h7fff;
	typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} asp_tx_type;
	typedef enum logic {RX_IDLE, RX_BITS} asp_rx_type;
endpackage

// [src/asp_uart.sv]
// Asynchronous serial port: baud generation, transmitter, receiver and APB registers.
// Assumes an APB master on CLK_SYS and a remote serial transceiver on the pins.
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module asp_uart #(
	parameter int FINE_W = 4
) (
	input  wire logic        CLK_SYS,
	input  wire logic        SYS_RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        SERIAL_IN,
	output logic             SERIAL_OUT,
	output logic             SHIFT_STROBE
);
	import asp_pkg::*;

	logic [7:0]        ctrl_ff;
	logic [7:0]        rx_buf_ff;
	logic [14:0]       reload_ff;
	logic [FINE_W-1:0] fine_ff;
	logic              dbl_ff;
	logic [7:0]        own_addr_ff;
	logic [7:0]        mask_ff;
	logic [31:0]       rdata_ff;
	logic [1:0]        mode;
	logic              nine;
	logic              wr;
	logic              mapped;
	logic              tx_set;
	logic              rx_load;
	logic              rx_ninth;

	// Match test; reset values make every byte match
	function automatic logic addr_match(input logic [7:0] b, input logic [7:0] a, input logic [7:0] m);
		logic given;
		logic bcast;
		given = ((b ^ a) & m) == 8'h00;
		bcast = ((~b) & (a | m)) == 8'h00;
		return given | bcast;
	endfunction

	assign mode = ctrl_ff[B_MODE_HI:B_MODE_LO];
	assign nine = mode[1];
	assign wr = PSEL & PENABLE & PWRITE;
	assign mapped = (PADDR == OFS_CTRL) | (PADDR == OFS_DATA) | (PADDR == OFS_BAUD) | (PADDR == OFS_FINE)
		| (PADDR == OFS_PCTL) | (PADDR == OFS_SLAVE) | (PADDR == OFS_MASK);
	// Zero wait states; unmapped access answers with an error
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~mapped;
	assign PRDATA = rdata_ff;

	// Control bits; hardware set wins over a clearing write
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			ctrl_ff <= CTRL_RST;
		end else begin
			if (wr && PADDR == OFS_CTRL) begin
				ctrl_ff <= PWDATA[7:0];
			end
			if (tx_set) begin
				ctrl_ff[B_TXDONE] <= 1'b1;
			end
			if (rx_load) begin
				ctrl_ff[B_RXDONE] <= 1'b1;
				ctrl_ff[B_RX9] <= rx_ninth;
			end
		end
	end

	// Baud, address and option registers
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			reload_ff <= BAUD_RST;
			fine_ff <= '0;
			dbl_ff <= 1'b0;
			own_addr_ff <= ADDR_RST;
			mask_ff <= ADDR_RST;
		end else if (wr) begin
			case (PADDR)
				OFS_BAUD: reload_ff <= PWDATA[14:0];
				OFS_FINE: fine_ff <= PWDATA[FINE_W-1:0];
				OFS_PCTL: dbl_ff <= PWDATA[0];
				OFS_SLAVE: own_addr_ff <= PWDATA[7:0];
				OFS_MASK: mask_ff <= PWDATA[7:0];
				default: ;
			endcase
		end
	end

	// Read data registered at the setup phase, stable through access
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			rdata_ff <= 32'h0;
		end else if (PSEL && !PENABLE) begin
			case (PADDR)
				OFS_CTRL: rdata_ff <= {24'h0, ctrl_ff};
				OFS_DATA: rdata_ff <= {24'h0, rx_buf_ff};
				OFS_BAUD: rdata_ff <= {17'h0, reload_ff};
				OFS_FINE: rdata_ff <= 32'(fine_ff);
				OFS_PCTL: rdata_ff <= {31'h0, dbl_ff};
				OFS_SLAVE: rdata_ff <= {24'h0, own_addr_ff};
				OFS_MASK: rdata_ff <= {24'h0, mask_ff};
				default: rdata_ff <= 32'h0;
			endcase
		end
	end

	// Oversample tick: 15-bit generator plus fine stretch, or fixed prescaler
	logic [14:0]       bgen_ff;
	logic [3:0]        sub_ff;
	logic [FINE_W-1:0] fcnt_ff;
	logic [1:0]        pre_ff;
	logic              ovf;
	logic              stretch;
	logic              tick;
	assign ovf = bgen_ff == BAUD_MAX;
	assign stretch = ovf && sub_ff == CNT_LAST && fcnt_ff != fine_ff;
	assign tick = (mode == MODE_FIX9) ? (pre_ff == (dbl_ff ? FIX_FAST_TICK : FIX_SLOW_TICK))
		: (mode[0] & ovf & ~stretch);

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			bgen_ff <= BAUD_RST;
			sub_ff <= 4'h0;
			fcnt_ff <= '0;
		end else if (ovf) begin
			// Stretch the last sixteenth by fine clocks for single-clock resolution
			if (stretch) begin
				fcnt_ff <= fcnt_ff + 1'b1;
			end else begin
				bgen_ff <= reload_ff;
				sub_ff <= sub_ff + 4'h1;
				fcnt_ff <= '0;
			end
		end else begin
			bgen_ff <= bgen_ff + 15'h1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST || tick || mode != MODE_FIX9) begin
			pre_ff <= 2'h0;
		end else begin
			pre_ff <= pre_ff + 2'h1;
		end
	end

	// Shift-mode rate strobe; framing of that mode is not built here
	logic [3:0] m0_ff;
	logic       strobe_ff;
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST || mode != MODE_SHIFT) begin
			m0_ff <= 4'h0;
			strobe_ff <= 1'b0;
		end else begin
			strobe_ff <= m0_ff == (ctrl_ff[B_MPE] ? SHIFT_FAST : SHIFT_SLOW);
			m0_ff <= strobe_ff ? 4'h1 : m0_ff + 4'h1;
		end
	end
	assign SHIFT_STROBE = strobe_ff;

	// Transmitter: bit times follow its own divide-by-16 counter, not the write
	asp_tx_type  tx_st_ff;
	logic [3:0]  tx_cnt_ff;
	logic [3:0]  tx_bit_ff;
	logic [8:0]  tx_sh_ff;
	logic        out_ff;
	logic        tx_roll;
	logic [3:0]  tx_last;
	assign tx_roll = tick && tx_cnt_ff == CNT_LAST;
	assign tx_last = nine ? 4'd10 : 4'd9;
	assign tx_set = tx_st_ff == TX_SEND && tx_roll && tx_bit_ff + 4'd1 == tx_last;

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			tx_cnt_ff <= 4'h0;
		end else if (tick) begin
			tx_cnt_ff <= tx_cnt_ff + 4'h1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			tx_st_ff <= TX_IDLE;
			tx_bit_ff <= 4'h0;
			tx_sh_ff <= 9'h1ff;
			out_ff <= 1'b1;
		end else begin
			case (tx_st_ff)
				TX_IDLE: begin
					if (wr && PADDR == OFS_DATA && mode != MODE_SHIFT) begin
						tx_sh_ff <= {ctrl_ff[B_TX9] | ~nine, PWDATA[7:0]};
						tx_st_ff <= TX_WAIT;
					end
				end
				TX_WAIT: begin
					if (tx_roll) begin
						out_ff <= 1'b0;
						tx_bit_ff <= 4'h0;
						tx_st_ff <= TX_SEND;
					end
				end
				TX_SEND: begin
					if (tx_roll) begin
						tx_bit_ff <= tx_bit_ff + 4'h1;
						if (tx_bit_ff == tx_last) begin
							tx_st_ff <= TX_IDLE;
						end else if (tx_bit_ff + 4'd1 == tx_last) begin
							out_ff <= 1'b1;
						end else begin
							out_ff <= tx_sh_ff[tx_bit_ff];
						end
					end
				end
				default: tx_st_ff <= TX_IDLE;
			endcase
		end
	end
	assign SERIAL_OUT = out_ff;

	// Input synchroniser; the first stage feeds only the second
	logic rx_m_ff;
	logic rx_s_ff;
	logic rx_d_ff;
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			rx_m_ff <= 1'b1;
			rx_s_ff <= 1'b1;
			rx_d_ff <= 1'b1;
		end else begin
			rx_m_ff <= SERIAL_IN;
			rx_s_ff <= rx_m_ff;
			rx_d_ff <= rx_s_ff;
		end
	end

	// Receiver: edge-aligned counter, 2-of-3 vote per bit
	asp_rx_type rx_st_ff;
	logic [3:0] rx_cnt_ff;
	logic [3:0] rx_bit_ff;
	logic [8:0] rx_sh_ff;
	logic [1:0] smp_ff;
	logic       fall;
	logic       vote;
	logic       decide;
	logic       rx_on;
	logic       accept;
	logic [3:0] rx_last;
	assign rx_on = ctrl_ff[B_RXEN] && mode != MODE_SHIFT;
	assign fall = rx_d_ff & ~rx_s_ff;
	assign vote = (smp_ff[0] & smp_ff[1]) | (smp_ff[0] & rx_s_ff) | (smp_ff[1] & rx_s_ff);
	assign decide = rx_st_ff == RX_BITS && tick && rx_cnt_ff == SMP_C;
	assign rx_last = nine ? 4'd10 : 4'd9;
	assign rx_ninth = nine ? rx_sh_ff[8] : vote;
	assign accept = !ctrl_ff[B_RXDONE] && (!ctrl_ff[B_MPE]
		|| (nine ? (rx_sh_ff[8] && addr_match(rx_sh_ff[7:0], own_addr_ff, mask_ff)) : vote));
	assign rx_load = decide && rx_bit_ff == rx_last && accept;

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST || !rx_on) begin
			rx_st_ff <= RX_IDLE;
			rx_cnt_ff <= 4'h0;
			rx_bit_ff <= 4'h0;
			smp_ff <= 2'h3;
		end else if (rx_st_ff == RX_IDLE) begin
			if (fall) begin
				rx_st_ff <= RX_BITS;
				rx_cnt_ff <= 4'h0;
				rx_bit_ff <= 4'h0;
			end
		end else if (tick) begin
			rx_cnt_ff <= rx_cnt_ff + 4'h1;
			if (rx_cnt_ff == SMP_A) begin
				smp_ff[0] <= rx_s_ff;
			end
			if (rx_cnt_ff == SMP_B) begin
				smp_ff[1] <= rx_s_ff;
			end
			if (decide) begin
				if (rx_bit_ff == 4'h0 && vote) begin
					rx_st_ff <= RX_IDLE;
				end else if (rx_bit_ff == rx_last) begin
					rx_st_ff <= RX_IDLE;
				end else begin
					rx_bit_ff <= rx_bit_ff + 4'h1;
				end
			end
		end
	end

	// Data bits by index; stop bit of 9-bit frames is never stored
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			rx_sh_ff <= 9'h0;
			rx_buf_ff <= 8'h0;
		end else begin
			if (decide && rx_bit_ff != 4'h0 && rx_bit_ff != rx_last) begin
				rx_sh_ff[rx_bit_ff - 4'h1] <= vote;
			end
			if (rx_load) begin
				rx_buf_ff <= rx_sh_ff[7:0];
			end
		end
	end

	// Checks on the transmit and receive behaviour
	// A tick, then the slow fixed rate held for four more clocks
	sequence s_fix_slow_run;
		(mode == MODE_FIX9 && !dbl_ff && tick) ##1 (mode == MODE_FIX9 && !dbl_ff) [*4];
	endsequence
	property p_fix_rate;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		s_fix_slow_run |-> (tick && !$past(tick) && !$past(tick, 2) && !$past(tick, 3));
	endproperty
	a_fix_rate: assert property (p_fix_rate) else $error("fixed rate tick spacing wrong");
	property p_start_low;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		(tx_st_ff == TX_WAIT && tx_roll) |=> (SERIAL_OUT == 1'b0 && tx_st_ff == TX_SEND);
	endproperty
	a_start_low: assert property (p_start_low) else $error("start bit not driven low");
	property p_stop_high;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		tx_set |=> (SERIAL_OUT && ctrl_ff[B_TXDONE]);
	endproperty
	a_stop_high: assert property (p_stop_high) else $error("stop bit and done flag disagree");
	property p_done_bits;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		tx_set |-> tx_bit_ff == (nine ? 4'd9 : 4'd8);
	endproperty
	a_done_bits: assert property (p_done_bits) else $error("done flag at wrong bit");
	property p_fall_reset;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		(rx_on && rx_st_ff == RX_IDLE && fall) |=> (rx_cnt_ff == 4'h0 && rx_st_ff == RX_BITS);
	endproperty
	a_fall_reset: assert property (p_fall_reset) else $error("edge did not clear counter");
	property p_abort;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		(decide && rx_bit_ff == 4'h0 && vote) |=> rx_st_ff == RX_IDLE;
	endproperty
	a_abort: assert property (p_abort) else $error("bad start bit not aborted");
	property p_rx_off;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		!ctrl_ff[B_RXEN] |=> rx_st_ff == RX_IDLE;
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("receiver active while disabled");
	property p_hold_full;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		ctrl_ff[B_RXDONE] |=> $stable(rx_buf_ff);
	endproperty
	a_hold_full: assert property (p_hold_full) else $error("buffer overwritten while flag set");
	property p_mp_filter;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		(rx_load && nine && ctrl_ff[B_MPE]) |=> ctrl_ff[B_RX9];
	endproperty
	a_mp_filter: assert property (p_mp_filter) else $error("data frame passed address filter");
	property p_vote_window;
		@(posedge CLK_SYS) disable iff (SYS_RST)
		(rx_on && rx_st_ff == RX_BITS && tick && rx_cnt_ff == SMP_B) |=> smp_ff[1] == $past(rx_s_ff);
	endproperty
	a_vote_window: assert property (p_vote_window) else $error("vote outside sample window");
endmodule
`default_nettype wire

// [sim/asp_remote.sv]
// Remote serial transceiver model facing the port's pins.
// Assumes the same system clock as the port; bit periods are given in clocks.
`timescale 1ns/1ps
`default_nettype none
module asp_remote (
	input  wire logic clk,
	input  wire logic line_in,
	output logic      line_out
);
	// Idle line rests at the stop level
	initial line_out = 1'h1;

	// Start low, data LSB first, ninth bit if asked, stop high
	task automatic send(input logic [8:0] val, input int nb, input int per);
		logic [10:0] f;
		f = 11'h7ff;
		f[0] = 1'h0;
		for (int i = 0; i < nb; i++) f[i + 1] = val[i];
		for (int i = 0; i <= nb + 1; i++) begin
			@(posedge clk);
			line_out <= f[i];
			repeat (per - 1) @(posedge clk);
		end
	endtask

	// Short low pulse, then quiet long enough for the receiver to give up
	task automatic glitch(input int n);
		@(posedge clk);
		line_out <= 1'h0;
		repeat (n) @(posedge clk);
		line_out <= 1'h1;
		repeat (n * 16) @(posedge clk);
	endtask

	// Mid-bit sampling from the start edge; also measures the start bit length
	task automatic recv(input int nb, input int per, output logic [9:0] d, output int low);
		int c;
		c = 0;
		low = 0;
		d = 10'h0;
		do @(posedge clk); while (line_in !== 1'h0);
		while (c < per / 2 + per * (nb + 1)) begin
			@(posedge clk);
			c++;
			if (line_in === 1'h1 && low == 0) low = c;
			if (c > per / 2 && (c - per / 2) % per == 0) d[(c - per / 2) / per - 1] = line_in;
		end
	endtask
endmodule
`default_nettype wire

// [sim/async_serial_port_modes_test.sv]
// Self-checking bench: APB register traffic and serial frames in three modes.
// Assumes the remote model on the pins and a single 50 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin num_errors++; \
	$display("BAD %s exp %0h got %0h", nm, ex, got); end end
module async_serial_port_modes_test;
	import asp_pkg::*;
	logic        clk_sys    = 1'h0;
	logic        sys_rst    = 1'h1;
	logic        psel       = 1'h0;
	logic        penable    = 1'h0;
	logic        pwrite     = 1'h0;
	logic [7:0]  paddr      = 8'h0;
	logic [31:0] pwdata     = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ser_in;
	logic        ser_out;
	logic        strobe;
	logic [31:0] v;
	logic        e;
	int          num_errors = 0;
	int          tests_run  = 0;

	// 20 ns period
	always #10 clk_sys = ~clk_sys;

	asp_uart #(.FINE_W(4)) i_asp_uart (
		.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.SERIAL_IN(ser_in), .SERIAL_OUT(ser_out), .SHIFT_STROBE(strobe));

	asp_remote i_remote (.clk(clk_sys), .line_in(ser_out), .line_out(ser_in));

	// One transfer; request held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk_sys);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk_sys);
		penable <= 1'h1;
		// No wait count assumed; only the watchdog ends a stuck access
		do @(posedge clk_sys); while (pready !== 1'h1);
		v = prdata;
		e = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask

	function automatic logic [31:0] ctl(input logic [1:0] m, input logic mp, input logic re, input logic t9);
		ctl = 32'h0;
		ctl[B_MODE_HI] = m[1];
		ctl[B_MODE_LO] = m[0];
		ctl[B_MPE] = mp;
		ctl[B_RXEN] = re;
		ctl[B_TX9] = t9;
	endfunction

	// Flag, ninth bit and buffer after a frame has been sent in
	task automatic expect_rx(input logic f, input logic [7:0] b, input logic n9);
		repeat (8) @(posedge clk_sys);
		apb(1'h0, OFS_CTRL, 32'h0);
		`CHK("rx_done_flag", f, v[B_RXDONE])
		if (f) begin
			`CHK("rx_ninth_bit", n9, v[B_RX9])
			apb(1'h0, OFS_DATA, 32'h0);
			`CHK("rx_buffer", b, v[7:0])
		end
	endtask

	// Byte out through the buffer; frame and start length seen at the far end
	task automatic tx_frame(input logic [7:0] b, input int nb, input int per, input logic [9:0] x, input int lo);
		logic [9:0] d;
		int         low;
		fork
			i_remote.recv(nb, per, d, low);
			apb(1'h1, OFS_DATA, {24'h0, b});
		join
		`CHK("tx_frame", x, d)
		if (lo > 0) `CHK("start_length", lo, low)
		apb(1'h0, OFS_CTRL, 32'h0);
		`CHK("tx_done_flag", 1'h1, v[B_TXDONE])
		// Cleared so that the next frame has to set it again
		apb(1'h1, OFS_CTRL, v & ~(32'h1 << B_TXDONE));
		repeat (per) @(posedge clk_sys);
	endtask

	// Clocks between two shift-rate strobes, after the rate has settled
	task automatic gap(input int x);
		int n;
		n = 0;
		repeat (16) @(posedge clk_sys);
		do @(posedge clk_sys); while (strobe !== 1'h1);
		do begin
			@(posedge clk_sys);
			n++;
		end while (strobe !== 1'h1 && n < 50);
		`CHK("strobe_gap", x, n)
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'h0;
		apb(1'h0, OFS_CTRL, 32'h0);
		`CHK("ctrl_reset", 32'h0, v)
		apb(1'h0, OFS_SLAVE, 32'h0);
		`CHK("addr_reset", 32'h0, v)
		apb(1'h0, OFS_MASK, 32'h0);
		`CHK("mask_reset", 32'h0, v)
		apb(1'h0, 8'h40, 32'h0);
		`CHK("unmapped_err", 1'h1, e)
		$display("test reset done");
		// Reload 7ffe gives two clocks a tick, 32 a bit
		apb(1'h1, OFS_BAUD, 32'h7ffe);
		apb(1'h1, OFS_CTRL, ctl(MODE_VAR8, 1'h0, 1'h1, 1'h0));
		tx_frame(8'ha5, 8, 32, {2'h1, 8'ha5}, 32);
		apb(1'h1, OFS_FINE, 32'h3);
		tx_frame(8'ha5, 8, 35, {2'h1, 8'ha5}, 35);
		apb(1'h1, OFS_FINE, 32'h0);
		$display("test var8 send done");
		i_remote.send(9'h3c, 8, 32);
		expect_rx(1'h1, 8'h3c, 1'h1);
		i_remote.send(9'hc3, 8, 32);
		expect_rx(1'h1, 8'h3c, 1'h1);
		apb(1'h1, OFS_CTRL, ctl(MODE_VAR8, 1'h0, 1'h1, 1'h0));
		i_remote.glitch(4);
		i_remote.send(9'h81, 8, 32);
		expect_rx(1'h1, 8'h81, 1'h1);
		apb(1'h1, OFS_CTRL, ctl(MODE_VAR8, 1'h0, 1'h0, 1'h0));
		i_remote.send(9'h55, 8, 32);
		expect_rx(1'h0, 8'h0, 1'h0);
		$display("test var8 receive done");
		// Fixed rate, doubled: 32 clocks a bit; given address 5x, broadcast fa
		apb(1'h1, OFS_PCTL, 32'h1);
		apb(1'h1, OFS_SLAVE, 32'h5a);
		apb(1'h1, OFS_MASK, 32'hf0);
		apb(1'h1, OFS_CTRL, ctl(MODE_FIX9, 1'h1, 1'h1, 1'h1));
		tx_frame(8'h97, 9, 32, {2'h3, 8'h97}, 32);
		i_remote.send(9'h05a, 9, 32);
		expect_rx(1'h0, 8'h0, 1'h0);
		i_remote.send(9'h111, 9, 32);
		expect_rx(1'h0, 8'h0, 1'h0);
		i_remote.send(9'h153, 9, 32);
		expect_rx(1'h1, 8'h53, 1'h1);
		apb(1'h1, OFS_CTRL, ctl(MODE_FIX9, 1'h1, 1'h1, 1'h1));
		i_remote.send(9'h1fb, 9, 32);
		expect_rx(1'h1, 8'hfb, 1'h1);
		$display("test fixed fast done");
		apb(1'h1, OFS_PCTL, 32'h0);
		apb(1'h1, OFS_CTRL, ctl(MODE_FIX9, 1'h0, 1'h1, 1'h0));
		tx_frame(8'h01, 9, 64, {2'h2, 8'h01}, 64);
		i_remote.send(9'h022, 9, 64);
		expect_rx(1'h1, 8'h22, 1'h0);
		$display("test fixed slow done");
		// Reload 7ffd: 48 clocks a bit
		apb(1'h1, OFS_BAUD, 32'h7ffd);
		apb(1'h1, OFS_CTRL, ctl(MODE_VAR9, 1'h0, 1'h1, 1'h1));
		tx_frame(8'h33, 9, 48, {2'h3, 8'h33}, 48);
		i_remote.send(9'h144, 9, 48);
		expect_rx(1'h1, 8'h44, 1'h1);
		$display("test var9 done");
		apb(1'h1, OFS_CTRL, ctl(MODE_SHIFT, 1'h0, 1'h0, 1'h0));
		gap(12);
		apb(1'h1, OFS_CTRL, ctl(MODE_SHIFT, 1'h1, 1'h0, 1'h0));
		gap(4);
		$display("test shift rate done");
		give_verdict();
	end

	// Cuts a hang short; a clean run needs about 40000 clocks, most of them the first generator overflow
	initial begin
		repeat (60000) @(posedge clk_sys);
		num_errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
